// file: src/cer_error_sideband.sv
// completion error sideband: sampling, status, message queue and register slave
//
// Contract
// - bridge takes a seven-bit error vector, one condition per bit
// - each report logs status and sends any required message automatically; a kind with 15 messages pending drops further ones
// - two errors from separate requests are both logged, never merged
// - bit 0: correctable completion timeout, send correctable message
// - bit 1: uncorrectable timeout, fatal or non-fatal by programmed severity
// - bit 2: completer abort sent, fatal or correctable by severity
// - bit 3: send fatal or correctable message by programmed severity
// - bit 4: posted request unsupported, fatal or non-fatal by severity
// - bit 5: unsupported request completion, message chosen by severity
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module cer_error_sideband (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [cer_pkg::ERR_W-1:0] faultVector,
   input wire logic [cer_pkg::PF_W-1:0] fault_physical_function_id,
   input wire logic fault_virtual_function_flag,
   input wire logic [cer_pkg::VF_W-1:0] fault_virtual_function_offset,
   input wire logic [cer_pkg::HDR_W-1:0] loggedHeader,
   input wire logic msgReady,
   output logic msgValid,
   output logic [1:0] msgSeverity,
   output logic [2:0] msgKind,
   output logic [cer_pkg::PF_W-1:0] msgPf,
   output logic msgVfFlag,
   output logic [cer_pkg::VF_W-1:0] msgVfOffset,
   input wire logic [cer_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic irq
);

   typedef enum logic {
      BUS_IDLE,
      BUS_ANSWER
   } cer_bus_state_type;

   cer_bus_state_type busState_q;
   logic [cer_pkg::ERR_W-1:0] vec_q;
   logic [cer_pkg::PF_W-1:0] pf_q;
   logic vfFlag_q;
   logic [cer_pkg::VF_W-1:0] vfOff_q;
   logic [cer_pkg::HDR_W-1:0] hdr_q;
   logic [cer_pkg::KIND_N-1:0] status_q;
   logic [cer_pkg::KIND_N-1:0] enable_q;
   logic [cer_pkg::KIND_N-1:0] severity_q;
   logic [cer_pkg::KIND_N*cer_pkg::CNT_W-1:0] countFlat;
   logic [cer_pkg::PF_W-1:0] logPf;
   logic logVfFlag;
   logic [cer_pkg::VF_W-1:0] logVfOffset;
   logic [cer_pkg::HDR_W-1:0] logHeader;
   logic logHeaderValid;
   logic [31:0] rdMux_d;
   logic wrStrobe;
   logic [cer_pkg::KIND_N-1:0] clearMask;

   ////////////////////////////////////////////////////////////////////////////
   // sample the vector and everything that travels with it on one edge
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         vec_q <= '0;
         pf_q <= '0;
         vfFlag_q <= 1'b0;
         vfOff_q <= '0;
         hdr_q <= '0;
      end else begin
         vec_q <= faultVector;
         pf_q <= fault_physical_function_id;
         vfFlag_q <= fault_virtual_function_flag;
         vfOff_q <= fault_virtual_function_offset;
         hdr_q <= loggedHeader;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // occurrence counters and last-report capture
   cer_fault_log u_log (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .sampleVec(vec_q),
      .samplePf(pf_q),
      .sampleVfFlag(vfFlag_q),
      .sampleVfOffset(vfOff_q),
      .sampleHeader(hdr_q),
      .countFlat(countFlat),
      .logPf(logPf),
      .logVfFlag(logVfFlag),
      .logVfOffset(logVfOffset),
      .logHeader(logHeader),
      .logHeaderValid(logHeaderValid)
   );

   // error messages, one per report while fewer than 15 of its kind are pending, severity from the severity register
   cer_msg_queue u_msg (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .reportPulse(vec_q[cer_pkg::KIND_N-1:0]),
      .reportPf(pf_q),
      .reportVfFlag(vfFlag_q),
      .reportVfOffset(vfOff_q),
      .fatalSel(severity_q),
      .msgReady(msgReady),
      .msgValid(msgValid),
      .msgSeverity(msgSeverity),
      .msgKind(msgKind),
      .msgPf(msgPf),
      .msgVfFlag(msgVfFlag),
      .msgVfOffset(msgVfOffset)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake: one wait cycle, then a single cycle with waitrequest low
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         busState_q <= BUS_IDLE;
         waitrequest <= 1'b1;
         readdata <= cer_pkg::RDATA_RST;
      end else begin
         case (busState_q)
            BUS_IDLE: begin
               if (read || write) begin
                  busState_q <= BUS_ANSWER;
                  waitrequest <= 1'b0;
                  readdata <= read ? rdMux_d : cer_pkg::RDATA_RST;
               end
            end
            BUS_ANSWER: begin
               busState_q <= BUS_IDLE;
               waitrequest <= 1'b1;
            end
            default: begin
               busState_q <= BUS_IDLE;
               waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // a write takes effect on the edge where waitrequest is seen low
   assign wrStrobe = write && (busState_q == BUS_ANSWER);
   assign clearMask = (wrStrobe && byteenable[0] && (address == cer_pkg::REG_CLEAR))
                      ? writedata[cer_pkg::KIND_N-1:0] : '0;

   ////////////////////////////////////////////////////////////////////////////
   // sticky event status: a new report wins over a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q & ~clearMask) | vec_q[cer_pkg::KIND_N-1:0];
      end
   end

   // interrupt enable register
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         enable_q <= cer_pkg::ENABLE_RST;
      end else if (wrStrobe && byteenable[0] && (address == cer_pkg::REG_ENABLE)) begin
         enable_q <= writedata[cer_pkg::KIND_N-1:0];
      end
   end

   // per-kind severity: 1 picks the fatal message, 0 the milder one; kind 0 always sends correctable
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         severity_q <= cer_pkg::SEVERITY_RST;
      end else if (wrStrobe && byteenable[0] && (address == cer_pkg::REG_SEVERITY)) begin
         severity_q <= writedata[cer_pkg::KIND_N-1:0];
      end
   end

   // level interrupt while any enabled status bit is set
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_q & enable_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read multiplexer; unmapped and write-only offsets read as zero
   always_comb begin
      rdMux_d = '0;
      case (address)
         cer_pkg::REG_STATUS: begin
            rdMux_d[cer_pkg::KIND_N-1:0] = status_q;
         end
         cer_pkg::REG_ENABLE: begin
            rdMux_d[cer_pkg::KIND_N-1:0] = enable_q;
         end
         cer_pkg::REG_SEVERITY: begin
            rdMux_d[cer_pkg::KIND_N-1:0] = severity_q;
         end
         cer_pkg::REG_LOG_FUNC: begin
            rdMux_d[cer_pkg::LOGF_PF_LSB +: cer_pkg::PF_W] = logPf;
            rdMux_d[cer_pkg::LOGF_VF_FLAG] = logVfFlag;
            rdMux_d[cer_pkg::LOGF_VF_LSB +: cer_pkg::VF_W] = logVfOffset;
            rdMux_d[cer_pkg::LOGF_HDR_VALID] = logHeaderValid;
         end
         default: begin
            for (int w = 0; w < cer_pkg::HDR_WORDS; w++) begin
               if (address == cer_pkg::REG_LOG_HDR0 + 6'(4 * w)) begin
                  rdMux_d = logHeader[w*32 +: 32];
               end
            end
            for (int c = 0; c < cer_pkg::KIND_N; c++) begin
               if (address == cer_pkg::REG_COUNT0 + 6'(4 * c)) begin
                  rdMux_d[cer_pkg::CNT_W-1:0] = countFlat[c*cer_pkg::CNT_W +: cer_pkg::CNT_W];
               end
            end
         end
      endcase
   end

endmodule : cer_error_sideband

`default_nettype wire

// file: src/cer_fault_log.sv
// occurrence counters and last-function / header capture for error reports
`timescale 1ns/1ps
`default_nettype none

module cer_fault_log (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [cer_pkg::ERR_W-1:0] sampleVec,
   input wire logic [cer_pkg::PF_W-1:0] samplePf,
   input wire logic sampleVfFlag,
   input wire logic [cer_pkg::VF_W-1:0] sampleVfOffset,
   input wire logic [cer_pkg::HDR_W-1:0] sampleHeader,
   output logic [cer_pkg::KIND_N*cer_pkg::CNT_W-1:0] countFlat,
   output logic [cer_pkg::PF_W-1:0] logPf,
   output logic logVfFlag,
   output logic [cer_pkg::VF_W-1:0] logVfOffset,
   output logic [cer_pkg::HDR_W-1:0] logHeader,
   output logic logHeaderValid
);

   ////////////////////////////////////////////////////////////////////////////
   // one saturating counter per error kind, so two reports are never merged
   genvar k;
   generate
      for (k = 0; k < cer_pkg::KIND_N; k++) begin : g_cnt
         logic [cer_pkg::CNT_W-1:0] cnt_q;
         always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
               cnt_q <= '0;
            end else if (sampleVec[k] && (cnt_q != {cer_pkg::CNT_W{1'b1}})) begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
         assign countFlat[k*cer_pkg::CNT_W +: cer_pkg::CNT_W] = cnt_q;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // the function of the latest report of any kind
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         logPf <= '0;
         logVfFlag <= 1'b0;
         logVfOffset <= '0;
      end else if (|sampleVec[cer_pkg::KIND_N-1:0]) begin
         logPf <= samplePf;
         logVfFlag <= sampleVfFlag;
         logVfOffset <= sampleVfFlag ? sampleVfOffset : '0;
      end
   end

   // header capture when the log-header bit comes with bits 2 to 5
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         logHeader <= '0;
         logHeaderValid <= 1'b0;
      end else if (sampleVec[cer_pkg::ERR_LOG_HDR] &&
                   (|sampleVec[cer_pkg::ERR_UR_NP:cer_pkg::ERR_CA_SENT])) begin
         logHeader <= sampleHeader;
         logHeaderValid <= 1'b1;
      end
   end

endmodule : cer_fault_log

`default_nettype wire

// file: src/cer_msg_queue.sv
// pending error messages per kind and their one-at-a-time issue
`timescale 1ns/1ps
`default_nettype none

module cer_msg_queue (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [cer_pkg::KIND_N-1:0] reportPulse,
   input wire logic [cer_pkg::PF_W-1:0] reportPf,
   input wire logic reportVfFlag,
   input wire logic [cer_pkg::VF_W-1:0] reportVfOffset,
   input wire logic [cer_pkg::KIND_N-1:0] fatalSel,
   input wire logic msgReady,
   output logic msgValid,
   output logic [1:0] msgSeverity,
   output logic [2:0] msgKind,
   output logic [cer_pkg::PF_W-1:0] msgPf,
   output logic msgVfFlag,
   output logic [cer_pkg::VF_W-1:0] msgVfOffset
);

   logic [cer_pkg::KIND_N-1:0] pendAny;
   logic [cer_pkg::KIND_N-1:0] take;
   logic [2:0] pick;
   logic launch;
   logic [cer_pkg::PF_W-1:0] pfTab [cer_pkg::KIND_N];
   logic vfTab [cer_pkg::KIND_N];
   logic [cer_pkg::VF_W-1:0] offTab [cer_pkg::KIND_N];

   // message class for a kind under its programmed severity
   function automatic logic [1:0] sev_of(input logic [2:0] kind, input logic fatal);
      logic [1:0] s;
      s = cer_pkg::SEV_CORRECTABLE;
      if (kind == 3'(cer_pkg::ERR_CTO_COR)) begin
         s = cer_pkg::SEV_CORRECTABLE;
      end else if (kind == 3'(cer_pkg::ERR_CTO_UNC) || kind == 3'(cer_pkg::ERR_UR_POSTED)) begin
         s = fatal ? cer_pkg::SEV_FATAL : cer_pkg::SEV_NONFATAL;
      end else begin
         s = fatal ? cer_pkg::SEV_FATAL : cer_pkg::SEV_CORRECTABLE;
      end
      return s;
   endfunction : sev_of

   ////////////////////////////////////////////////////////////////////////////
   // per-kind pending count; a report and an issue in one cycle cancel out
   genvar k;
   generate
      for (k = 0; k < cer_pkg::KIND_N; k++) begin : g_pend
         logic [cer_pkg::PEND_W-1:0] pend_q;
         always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
               pend_q <= '0;
            end else if (reportPulse[k] && !take[k]) begin
               if (pend_q != {cer_pkg::PEND_W{1'b1}}) begin
                  pend_q <= pend_q + 1'b1;
               end
            end else if (!reportPulse[k] && take[k]) begin
               pend_q <= pend_q - 1'b1;
            end
         end
         // function of the newest report of this kind travels with its message
         always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
               pfTab[k] <= '0;
               vfTab[k] <= 1'b0;
               offTab[k] <= '0;
            end else if (reportPulse[k]) begin
               pfTab[k] <= reportPf;
               vfTab[k] <= reportVfFlag;
               offTab[k] <= reportVfOffset;
            end
         end
         assign pendAny[k] = (pend_q != '0);
         assign take[k] = launch && (pick == 3'(k));
      end
   endgenerate

   // lowest pending kind goes first once the output slot is free
   always_comb begin
      pick = '0;
      for (int i = cer_pkg::KIND_N - 1; i >= 0; i--) begin
         if (pendAny[i]) begin
            pick = 3'(i);
         end
      end
      launch = (|pendAny) && (!msgValid || msgReady);
   end

   ////////////////////////////////////////////////////////////////////////////
   // message output, held until the sender takes it
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         msgValid <= 1'b0;
         msgSeverity <= cer_pkg::SEV_CORRECTABLE;
         msgKind <= '0;
         msgPf <= '0;
         msgVfFlag <= 1'b0;
         msgVfOffset <= '0;
      end else if (launch) begin
         msgValid <= 1'b1;
         msgSeverity <= sev_of(pick, fatalSel[pick]);
         msgKind <= pick;
         msgPf <= pfTab[pick];
         msgVfFlag <= vfTab[pick];
         msgVfOffset <= offTab[pick];
      end else if (msgReady) begin
         msgValid <= 1'b0;
      end
   end

endmodule : cer_msg_queue

`default_nettype wire

// file: src/cer_pkg.sv
// constants shared by the completion error reporting block
package cer_pkg;

   // error vector layout
   localparam int unsigned ERR_W = 7;
   localparam int unsigned KIND_N = 6;
   localparam int unsigned ERR_CTO_COR = 0;
   localparam int unsigned ERR_CTO_UNC = 1;
   localparam int unsigned ERR_CA_SENT = 2;
   localparam int unsigned ERR_UNEXP_CPL = 3;
   localparam int unsigned ERR_UR_POSTED = 4;
   localparam int unsigned ERR_UR_NP = 5;
   localparam int unsigned ERR_LOG_HDR = 6;

   // function identification and header widths
   localparam int unsigned PF_W = 2;
   localparam int unsigned VF_W = 11;
   localparam int unsigned HDR_W = 128;
   localparam int unsigned HDR_WORDS = 4;

   // per-kind occurrence counter and pending message counter widths
   localparam int unsigned CNT_W = 16;
   localparam int unsigned PEND_W = 4;

   // error message severity codes
   localparam logic [1:0] SEV_CORRECTABLE = 2'h0;
   localparam logic [1:0] SEV_NONFATAL = 2'h1;
   localparam logic [1:0] SEV_FATAL = 2'h2;

   // register byte offsets
   localparam int unsigned ADDR_W = 6;
   localparam logic [5:0] REG_STATUS = 6'h00;
   localparam logic [5:0] REG_CLEAR = 6'h04;
   localparam logic [5:0] REG_ENABLE = 6'h08;
   localparam logic [5:0] REG_SEVERITY = 6'h0c;
   localparam logic [5:0] REG_LOG_FUNC = 6'h10;
   localparam logic [5:0] REG_LOG_HDR0 = 6'h14;
   localparam logic [5:0] REG_COUNT0 = 6'h24;

   // log function register fields
   localparam int unsigned LOGF_PF_LSB = 0;
   localparam int unsigned LOGF_VF_FLAG = 4;
   localparam int unsigned LOGF_VF_LSB = 8;
   localparam int unsigned LOGF_HDR_VALID = 31;

   // values after reset
   localparam logic [5:0] ENABLE_RST = 6'h00;
   localparam logic [5:0] SEVERITY_RST = 6'h00;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

endpackage : cer_pkg

// file: verification/cer_app_model.sv
// application-side model: error pulses, reporter identity, header and message sink
`timescale 1ns/1ps
`default_nettype none

module cer_app_model (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic fire,
   input wire logic [6:0] fireVec,
   input wire logic [1:0] firePf,
   input wire logic fireVf,
   input wire logic [10:0] fireOff,
   input wire logic [127:0] fireHdr,
   input wire logic stallMode,
   output logic [6:0] faultVector,
   output logic [1:0] pfId,
   output logic vfFlag,
   output logic [10:0] vfOffset,
   output logic [127:0] header,
   output logic msgReady
);
   logic [1:0] stall_q;

   // one pulse per occurrence; completions themselves go out elsewhere
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         faultVector <= 7'h00;
      end else begin
         faultVector <= fire ? fireVec : 7'h00;
      end
   end

   // identity and header valid only with a pulse, garbled otherwise
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         {pfId, vfFlag, vfOffset, header} <= '0;
      end else if (fire) begin
         {pfId, vfFlag, vfOffset} <= {firePf, fireVf, fireOff};
         header <= (fireVec[6] && |fireVec[5:2]) ? fireHdr : ~header;
      end else begin
         {pfId, vfFlag, vfOffset, header} <= ~{pfId, vfFlag, vfOffset, header};
      end
   end

   // message sink: ready every cycle, or one cycle in four when stalling
   always_ff @(posedge ref_clk) begin
      stall_q <= reset_n ? stall_q + 2'h1 : 2'h0;
      msgReady <= reset_n && (!stallMode || stall_q == 2'h0);
   end
endmodule : cer_app_model
`default_nettype wire

// file: verification/cer_error_sideband_assertions.sv
// concurrent checks on the ports of the completion error sideband
`timescale 1ns/1ps
`default_nettype none

module cer_error_sideband_assertions (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [6:0] faultVector,
   input wire logic msgReady,
   input wire logic msgValid,
   input wire logic [1:0] msgSeverity,
   input wire logic [2:0] msgKind,
   input wire logic [1:0] msgPf,
   input wire logic msgVfFlag,
   input wire logic [10:0] msgVfOffset,
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   // steps of a bus answer, a stalled message and a report
   sequence busAnswer;
      !waitrequest ##1 waitrequest;
   endsequence
   sequence msgStall;
      msgValid && !msgReady;
   endsequence
   sequence reportSeen;
      faultVector[5:0] != 6'h00;
   endsequence

   wait_pulse_a: assert property ((read || write) && waitrequest |=> busAnswer)
      else $error("bus answer not a single cycle");
   idle_answer_a: assert property (!(read || write) |=> waitrequest)
      else $error("bus answered without a request");
   msg_hold_a: assert property (msgStall |=> msgValid &&
      $stable({msgKind, msgSeverity, msgPf, msgVfFlag, msgVfOffset}))
      else $error("message changed while stalled");
   report_msg_a: assert property (reportSeen |-> ##[2:300] msgValid)
      else $error("report produced no message");
   kind_legal_a: assert property (msgValid |-> msgKind <= 3'h5)
      else $error("message kind out of range");
   cor_timeout_a: assert property (msgValid && msgKind == 3'h0 |-> msgSeverity == 2'h0)
      else $error("recoverable timeout not correctable");
   unc_kinds_a: assert property (
      msgValid && msgKind inside {3'h1, 3'h4} |-> msgSeverity inside {2'h1, 2'h2})
      else $error("timeout or posted kind has wrong severity");
   fat_cor_kinds_a: assert property (
      msgValid && msgKind inside {3'h2, 3'h3, 3'h5} |-> msgSeverity inside {2'h0, 2'h2})
      else $error("abort or completion kind has wrong severity");
endmodule : cer_error_sideband_assertions

bind cer_error_sideband cer_error_sideband_assertions chk (.ref_clk(ref_clk), .reset_n(reset_n),
   .faultVector(faultVector), .msgReady(msgReady), .msgValid(msgValid),
   .msgSeverity(msgSeverity), .msgKind(msgKind), .msgPf(msgPf), .msgVfFlag(msgVfFlag),
   .msgVfOffset(msgVfOffset), .read(read), .write(write), .waitrequest(waitrequest));
`default_nettype wire

// file: verification/cer_error_sideband_test.sv
// self-checking bench for the completion error sideband
`timescale 1ns/1ps
`default_nettype none

module cer_error_sideband_test;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [5:0] address = 6'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic fire = 1'b0;
   logic [6:0] fireVec = 7'h00;
   logic [1:0] firePf = 2'h0;
   logic fireVf = 1'b0;
   logic [10:0] fireOff = 11'h000;
   logic [127:0] fireHdr = '0;
   logic stallMode = 1'b0;
   logic [6:0] faultVector;
   logic [1:0] pfId, msgSeverity, msgPf;
   logic vfFlag, msgReady, msgValid, msgVfFlag, waitrequest, irq;
   logic [10:0] vfOffset, msgVfOffset;
   logic [127:0] header;
   logic [2:0] msgKind;
   logic [31:0] readdata, rd;
   logic [31:0] seed = 32'hdf73;
   logic [15:0] cnt [6] = '{default: 16'h0};
   logic [18:0] msgQ [$];
   int miscompares = 0;
   int checks = 0;

   always #12.5 ref_clk = ~ref_clk;

   cer_app_model app (.ref_clk(ref_clk), .reset_n(reset_n), .fire(fire), .fireVec(fireVec),
      .firePf(firePf), .fireVf(fireVf), .fireOff(fireOff), .fireHdr(fireHdr),
      .stallMode(stallMode), .faultVector(faultVector), .pfId(pfId), .vfFlag(vfFlag),
      .vfOffset(vfOffset), .header(header), .msgReady(msgReady));

   cer_error_sideband DUT (.ref_clk(ref_clk), .reset_n(reset_n), .faultVector(faultVector),
      .fault_physical_function_id(pfId), .fault_virtual_function_flag(vfFlag),
      .fault_virtual_function_offset(vfOffset), .loggedHeader(header), .msgReady(msgReady),
      .msgValid(msgValid), .msgSeverity(msgSeverity), .msgKind(msgKind), .msgPf(msgPf),
      .msgVfFlag(msgVfFlag), .msgVfOffset(msgVfOffset), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq));

   // record every message the sink takes
   always @(posedge ref_clk) begin
      if (reset_n && msgValid === 1'b1 && msgReady === 1'b1) begin
         msgQ.push_back({msgKind, msgSeverity, msgPf, msgVfFlag, msgVfOffset});
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return x[0] ? ((x >> 1) ^ 32'h8020_0003) : (x >> 1);
   endfunction : lfsr

   // severity expected for a kind under its severity bit
   function automatic logic [1:0] expSev(input int k, input logic fat);
      if (k == 0) return cer_pkg::SEV_CORRECTABLE;
      if (fat) return cer_pkg::SEV_FATAL;
      return (k == 1 || k == 4) ? cer_pkg::SEV_NONFATAL : cer_pkg::SEV_CORRECTABLE;
   endfunction : expSev

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one register access; holds the request until waitrequest is seen low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      address <= a;
      write <= wr;
      read <= !wr;
      writedata <= wd;
      @(posedge ref_clk);
      while (waitrequest !== 1'b0 && n < 50) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 50) miscompares++;
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge ref_clk);
   endtask : bus

   // one report cycle with random identity and header
   task automatic pulse(input logic [6:0] v);
      seed = lfsr(seed);
      fire <= 1'b1;
      fireVec <= v;
      {firePf, fireVf, fireOff} <= seed[13:0];
      fireHdr <= {seed, ~seed, seed ^ 32'h5a5a_5a5a, seed[15:0], seed[31:16]};
      for (int k = 0; k < 6; k++) if (v[k]) cnt[k]++;
      @(posedge ref_clk);
   endtask : pulse

   task automatic quiet(input int c);
      fire <= 1'b0;
      repeat (c) @(posedge ref_clk);
   endtask : quiet

   task automatic waitMsgs(input int n);
      int t;
      t = 0;
      while (msgQ.size() < n && t < 400) begin
         @(posedge ref_clk);
         t++;
      end
      check("message count", msgQ.size(), n);
   endtask : waitMsgs

   task automatic end_of_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [18:0] m;
      int n;
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      // reset values across the whole map, unmapped places included
      for (int a = 0; a < 64; a += 4) begin
         bus(1'b0, 6'(a), 32'h0);
         check("reset value", rd, 32'h0);
      end
      $display("test reset values done");
      // every kind under both severity settings
      for (int s = 0; s < 2; s++) begin
         for (int k = 0; k < 6; k++) begin
            bus(1'b1, cer_pkg::REG_SEVERITY, s ? 32'h3f : 32'h0);
            msgQ.delete();
            pulse(7'h01 << k);
            quiet(1);
            waitMsgs(1);
            m = msgQ.pop_front();
            check("message kind", m[18:16], k);
            check("severity", m[15:14], expSev(k, s));
            check("message function", m[13:0], {firePf, fireVf, fireOff});
            bus(1'b0, cer_pkg::REG_STATUS, 32'h0);
            check("status", rd, 32'h1 << k);
            bus(1'b0, cer_pkg::REG_COUNT0 + 6'(4 * k), 32'h0);
            check("count", rd, cnt[k]);
            bus(1'b1, cer_pkg::REG_CLEAR, 32'h3f);
         end
      end
      $display("test kinds done");
      // back-to-back reports, two kinds in one cycle, stalling sink
      stallMode <= 1'b1;
      msgQ.delete();
      pulse(7'h09);
      pulse(7'h08);
      quiet(2);
      waitMsgs(3);
      check("first kind", msgQ[0][18:16], 32'h0);
      check("last kind", msgQ[2][18:16], 32'h3);
      bus(1'b0, cer_pkg::REG_COUNT0 + 6'h0c, 32'h0);
      check("unmerged count", rd, cnt[3]);
      bus(1'b0, cer_pkg::REG_LOG_FUNC, 32'h0);
      check("log function", rd[18:0],
            {fireVf ? fireOff : 11'h000, 3'h0, fireVf, 2'h0, firePf});
      $display("test back to back done");
      // header captured with the logging bit
      pulse(7'h44);
      quiet(3);
      for (int w = 0; w < 4; w++) begin
         bus(1'b0, cer_pkg::REG_LOG_HDR0 + 6'(4 * w), 32'h0);
         check("header word", rd, fireHdr[32 * w +: 32]);
      end
      bus(1'b0, cer_pkg::REG_LOG_FUNC, 32'h0);
      check("header valid", rd[31], 1'b1);
      $display("test header done");
      // interrupt raised, masked, unmasked and cleared; status is read-only
      bus(1'b1, cer_pkg::REG_CLEAR, 32'h3f);
      bus(1'b1, cer_pkg::REG_ENABLE, 32'h20);
      pulse(7'h20);
      quiet(4);
      check("irq raised", irq, 1'b1);
      bus(1'b1, cer_pkg::REG_ENABLE, 32'h0);
      quiet(2);
      check("irq masked", irq, 1'b0);
      bus(1'b1, cer_pkg::REG_ENABLE, 32'h20);
      quiet(2);
      check("irq unmasked", irq, 1'b1);
      bus(1'b1, cer_pkg::REG_CLEAR, 32'h20);
      bus(1'b1, cer_pkg::REG_STATUS, 32'h3f);
      quiet(2);
      check("irq cleared", irq, 1'b0);
      bus(1'b0, cer_pkg::REG_STATUS, 32'h0);
      check("status cleared", rd, 32'h0);
      $display("test interrupt done");
      // random reports, several kinds per cycle, sink stalling at random
      msgQ.delete();
      n = 0;
      repeat (40) begin
         seed = lfsr(seed);
         stallMode <= seed[31];
         n += $countones(seed[21:16]);
         pulse({1'b0, seed[21:16]});
         quiet(14);
      end
      waitMsgs(n);
      for (int k = 0; k < 6; k++) begin
         bus(1'b0, cer_pkg::REG_COUNT0 + 6'(4 * k), 32'h0);
         check("random count", rd, cnt[k]);
      end
      $display("test random done");
      end_of_test();
   end

   // watchdog well beyond the expected length of the run
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      end_of_test();
   end
endmodule : cer_error_sideband_test
`default_nettype wire
